// File: hdl/adc_cfg_pkg.sv
package adc_cfg_pkg;
	localparam logic [31:0] OFS_HIGH_FREQ_B = 32'h0000_0000;
	localparam logic [31:0] OFS_PEDESTAL_A = 32'h0000_0004;
	localparam logic [31:0] OFS_PEDESTAL_B = 32'h0000_0008;
	localparam logic [31:0] OFS_LOOP_CTRL = 32'h0000_000c;
	localparam logic [31:0] OFS_SLOW_SEL_B = 32'h0000_0010;
	localparam logic [31:0] OFS_SLOW_GATE = 32'h0000_0014;
	localparam logic [31:0] OFS_SWING_GATE = 32'h0000_0018;
	localparam logic [31:0] OFS_SLOW_SEL_A = 32'h0000_001c;
	localparam logic [31:0] OFS_CORR_ENABLE = 32'h0000_0020;
	localparam logic [31:0] OFS_DATA_FORMAT = 32'h0000_0024;
	localparam logic [31:0] OFS_SWING_CODE = 32'h0000_0028;
	localparam logic [31:0] OFS_STATUS = 32'h0000_002c;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] MASK_HIGH_FREQ = 8'h01;
	localparam logic [7:0] MASK_PEDESTAL = 8'hfc;
	localparam logic [7:0] MASK_LOOP = 8'hbc;
	localparam logic [7:0] MASK_SLOW_B = 8'h01;
	localparam logic [7:0] MASK_SLOW_GATE = 8'h10;
	localparam logic [7:0] MASK_SWING_GATE = 8'h03;
	localparam logic [7:0] MASK_SLOW_A = 8'h08;
	localparam logic [7:0] MASK_CORR = 8'h20;
	localparam logic [7:0] MASK_FORMAT = 8'h18;
	localparam logic [7:0] MASK_SWING = 8'hfc;
	localparam int BIT_HIGH_FREQ_B = 0;
	localparam int BIT_HOLD = 7;
	localparam int TC_LSB = 2;
	localparam int TC_MSB = 5;
	localparam int BIT_SLOW_B = 0;
	localparam int BIT_SLOW_A = 3;
	localparam int BIT_SLOW_GATE = 4;
	localparam int BIT_CORR_EN = 5;
	localparam int FMT_LSB = 3;
	localparam int FMT_MSB = 4;
	localparam int PED14_LSB = 2;
	localparam int PED12_LSB = 4;
	localparam int PED_MSB = 7;
	localparam int SWING_LSB = 2;
	localparam int SWING_MSB = 7;
	localparam logic [1:0] SWING_GATE_ON = 2'h3;
	localparam logic [1:0] FMT_OFFSET_BIN = 2'h3;
	localparam logic [5:0] SWING_DEFAULT = 6'h00;
	localparam int LATENCY_CYCLES = 16;
	localparam int TC_BASE_SHIFT = 4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b11
	} bus_state_t;
endpackage

// File: hdl/offset_estimator.sv
`timescale 1ns/10ps
module offset_estimator
	import adc_cfg_pkg::*;
#(
	parameter int DATA_W = 14,
	parameter int ACC_W = 40
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic hold_i,
	input wire logic [3:0] tc_i,
	input wire logic signed [DATA_W-1:0] pedestal_i,
	input wire logic signed [DATA_W-1:0] sample_i,
	output logic signed [DATA_W-1:0] corrected_o
);
	logic signed [ACC_W-1:0] acc_ff;
	logic signed [ACC_W-1:0] err;
	logic signed [DATA_W-1:0] estimate;
	logic signed [DATA_W+1:0] diff;
	logic signed [ACC_W-1:0] step;
	logic [5:0] shift;

	// Fixed fraction bits, so a new time constant leaves the estimate in place
	localparam int FRAC_W = TC_BASE_SHIFT + (1 << $bits(tc_i)) - 1;

	assign shift = 6'(TC_BASE_SHIFT) + {2'h0, tc_i};
	assign estimate = DATA_W'(acc_ff >>> FRAC_W);
	assign diff = (DATA_W+2)'(sample_i) - (DATA_W+2)'(estimate) + (DATA_W+2)'(pedestal_i);
	assign err = ACC_W'(sample_i) - ACC_W'(estimate);
	assign step = (err <<< FRAC_W) >>> shift;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_ff <= '0;
		end else if (enable_i && !hold_i) begin
			acc_ff <= acc_ff + step;
		end
	end

	always_comb begin
		corrected_o = sample_i;
		if (enable_i) begin
			if (diff > (DATA_W+2)'(2**(DATA_W-1)-1)) begin
				corrected_o = DATA_W'(2**(DATA_W-1)-1);
			end else if (diff < -(DATA_W+2)'(2**(DATA_W-1))) begin
				corrected_o = DATA_W'(-(2**(DATA_W-1)));
			end else begin
				corrected_o = DATA_W'(diff);
			end
		end
	end
endmodule

// File: hdl/latency_line.sv
`timescale 1ns/10ps
module latency_line #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 15
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] data_i,
	output logic [WIDTH-1:0] data_o
);
	logic [WIDTH-1:0] stage_ff [DEPTH];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_ff[i] <= '0;
			end
		end else begin
			stage_ff[0] <= data_i;
			for (int i = 1; i < DEPTH; i++) begin
				stage_ff[i] <= stage_ff[i-1];
			end
		end
	end

	assign data_o = stage_ff[DEPTH-1];
endmodule

// File: hdl/adc_offset_and_mode_config.sv
`timescale 1ns/10ps
module adc_offset_and_mode_config
	import adc_cfg_pkg::*;
#(
	parameter int DATA_W = 14
) (
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic [DATA_W-1:0] SAMPLE_A_I,
	input wire logic [DATA_W-1:0] SAMPLE_B_I,
	output logic [DATA_W-1:0] DATA_A_O,
	output logic [DATA_W-1:0] DATA_B_O,
	output logic HIGH_FREQ_B_O,
	output logic SLOW_RATE_A_O,
	output logic SLOW_RATE_B_O,
	output logic [5:0] SWING_CODE_O
);
	localparam int PIPE_W = 2 * DATA_W;

	logic [7:0] high_freq_ff;
	logic [7:0] ped_a_ff;
	logic [7:0] ped_b_ff;
	logic [7:0] loop_ff;
	logic [7:0] slow_b_ff;
	logic [7:0] slow_gate_ff;
	logic [7:0] swing_gate_ff;
	logic [7:0] slow_a_ff;
	logic [7:0] corr_ff;
	logic [7:0] fmt_ff;
	logic [7:0] swing_ff;
	bus_state_t bus_state_ff;
	logic [31:0] addr_ff;
	logic [31:0] nxt_rdata;
	logic [DATA_W-1:0] samp_a_ff;
	logic [DATA_W-1:0] samp_b_ff;
	logic [DATA_W-1:0] data_a_ff;
	logic [DATA_W-1:0] data_b_ff;
	logic high_freq_b_ff;
	logic slow_a_out_ff;
	logic slow_b_out_ff;
	logic [5:0] swing_out_ff;
	logic signed [DATA_W-1:0] ped_a_ext;
	logic signed [DATA_W-1:0] ped_b_ext;
	logic signed [DATA_W-1:0] corr_a;
	logic signed [DATA_W-1:0] corr_b;
	logic [PIPE_W-1:0] pipe_out;
	logic corr_on;
	logic hold_on;
	logic take;
	logic [DATA_W-1:0] fmt_a;
	logic [DATA_W-1:0] fmt_b;

	// Pedestal field to signed offset, width chosen by resolution
	function automatic logic signed [DATA_W-1:0] pedestal_ext(input logic [7:0] reg_val);
		logic signed [DATA_W-1:0] v;
		v = '0;
		if (DATA_W >= 14) begin
			v = DATA_W'($signed(reg_val[PED_MSB:PED14_LSB]));
		end else begin
			v = DATA_W'($signed(reg_val[PED_MSB:PED12_LSB]));
		end
		return v;
	endfunction

	// Twos complement to output format
	function automatic logic [DATA_W-1:0] out_format(input logic [DATA_W-1:0] v,
		input logic [1:0] f);
		logic [DATA_W-1:0] r;
		r = v;
		if (f == FMT_OFFSET_BIN) begin
			r = {~v[DATA_W-1], v[DATA_W-2:0]};
		end
		return r;
	endfunction

	// Writable bits of each register
	// Unmapped offsets have none
	function automatic logic [7:0] reg_mask(input logic [31:0] a);
		logic [7:0] m;
		m = '0;
		unique case (a)
			OFS_HIGH_FREQ_B: m = MASK_HIGH_FREQ;
			OFS_PEDESTAL_A: m = MASK_PEDESTAL;
			OFS_PEDESTAL_B: m = MASK_PEDESTAL;
			OFS_LOOP_CTRL: m = MASK_LOOP;
			OFS_SLOW_SEL_B: m = MASK_SLOW_B;
			OFS_SLOW_GATE: m = MASK_SLOW_GATE;
			OFS_SWING_GATE: m = MASK_SWING_GATE;
			OFS_SLOW_SEL_A: m = MASK_SLOW_A;
			OFS_CORR_ENABLE: m = MASK_CORR;
			OFS_DATA_FORMAT: m = MASK_FORMAT;
			OFS_SWING_CODE: m = MASK_SWING;
			default: m = '0;
		endcase
		return m;
	endfunction

	// AHB-Lite slave: one wait-free data phase
	assign take = HSEL_I && HREADY_I && HTRANS_I[1];

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			bus_state_ff <= BUS_IDLE;
			addr_ff <= '0;
		end else begin
			if (take) begin
				bus_state_ff <= HWRITE_I ? BUS_WRITE : BUS_READ;
				addr_ff <= HADDR_I;
			end else begin
				bus_state_ff <= BUS_IDLE;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
		end else begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			high_freq_ff <= REG_RESET;
			ped_a_ff <= REG_RESET;
			ped_b_ff <= REG_RESET;
			loop_ff <= REG_RESET;
			slow_b_ff <= REG_RESET;
			slow_gate_ff <= REG_RESET;
			swing_gate_ff <= REG_RESET;
			slow_a_ff <= REG_RESET;
			corr_ff <= REG_RESET;
			fmt_ff <= REG_RESET;
			swing_ff <= REG_RESET;
		end else if (bus_state_ff == BUS_WRITE) begin
			// Reserved bits are masked off and read as zero
			unique case (addr_ff)
				OFS_HIGH_FREQ_B: high_freq_ff <= HWDATA_I[7:0] & MASK_HIGH_FREQ;
				OFS_PEDESTAL_A: ped_a_ff <= HWDATA_I[7:0] & MASK_PEDESTAL;
				OFS_PEDESTAL_B: ped_b_ff <= HWDATA_I[7:0] & MASK_PEDESTAL;
				OFS_LOOP_CTRL: loop_ff <= HWDATA_I[7:0] & MASK_LOOP;
				OFS_SLOW_SEL_B: slow_b_ff <= HWDATA_I[7:0] & MASK_SLOW_B;
				OFS_SLOW_GATE: slow_gate_ff <= HWDATA_I[7:0] & MASK_SLOW_GATE;
				OFS_SWING_GATE: swing_gate_ff <= HWDATA_I[7:0] & MASK_SWING_GATE;
				OFS_SLOW_SEL_A: slow_a_ff <= HWDATA_I[7:0] & MASK_SLOW_A;
				OFS_CORR_ENABLE: corr_ff <= HWDATA_I[7:0] & MASK_CORR;
				OFS_DATA_FORMAT: fmt_ff <= HWDATA_I[7:0] & MASK_FORMAT;
				OFS_SWING_CODE: swing_ff <= HWDATA_I[7:0] & MASK_SWING;
				default: ;
			endcase
		end
	end

	always_comb begin
		nxt_rdata = '0;
		unique case (HADDR_I)
			OFS_HIGH_FREQ_B: nxt_rdata[7:0] = high_freq_ff;
			OFS_PEDESTAL_A: nxt_rdata[7:0] = ped_a_ff;
			OFS_PEDESTAL_B: nxt_rdata[7:0] = ped_b_ff;
			OFS_LOOP_CTRL: nxt_rdata[7:0] = loop_ff;
			OFS_SLOW_SEL_B: nxt_rdata[7:0] = slow_b_ff;
			OFS_SLOW_GATE: nxt_rdata[7:0] = slow_gate_ff;
			OFS_SWING_GATE: nxt_rdata[7:0] = swing_gate_ff;
			OFS_SLOW_SEL_A: nxt_rdata[7:0] = slow_a_ff;
			OFS_CORR_ENABLE: nxt_rdata[7:0] = corr_ff;
			OFS_DATA_FORMAT: nxt_rdata[7:0] = fmt_ff;
			OFS_SWING_CODE: nxt_rdata[7:0] = swing_ff;
			OFS_STATUS: nxt_rdata[3:0] = {swing_out_ff == swing_ff[SWING_MSB:SWING_LSB],
				slow_a_out_ff, slow_b_out_ff, high_freq_b_ff};
			default: nxt_rdata = '0;
		endcase
		// A read right behind a write to the same register sees the new value
		if (bus_state_ff == BUS_WRITE && addr_ff == HADDR_I && reg_mask(HADDR_I) != '0) begin
			nxt_rdata = {24'h0, HWDATA_I[7:0] & reg_mask(HADDR_I)};
		end
	end

	// Read data registered at the address phase edge, valid in the data phase
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			HRDATA_O <= '0;
		end else if (take && !HWRITE_I) begin
			HRDATA_O <= nxt_rdata;
		end
	end

	// Mode outputs
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			high_freq_b_ff <= 1'b0;
		end else begin
			high_freq_b_ff <= high_freq_ff[BIT_HIGH_FREQ_B];
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			slow_b_out_ff <= 1'b0;
		end else begin
			slow_b_out_ff <= slow_b_ff[BIT_SLOW_B] && slow_gate_ff[BIT_SLOW_GATE];
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			slow_a_out_ff <= 1'b0;
		end else begin
			slow_a_out_ff <= slow_a_ff[BIT_SLOW_A] && slow_gate_ff[BIT_SLOW_GATE];
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			swing_out_ff <= SWING_DEFAULT;
		end else if (swing_gate_ff[1:0] == SWING_GATE_ON) begin
			swing_out_ff <= swing_ff[SWING_MSB:SWING_LSB];
		end else begin
			swing_out_ff <= SWING_DEFAULT;
		end
	end

	assign HIGH_FREQ_B_O = high_freq_b_ff;
	assign SLOW_RATE_A_O = slow_a_out_ff;
	assign SLOW_RATE_B_O = slow_b_out_ff;
	assign SWING_CODE_O = swing_out_ff;

	// Both channels captured on the same edge
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			samp_a_ff <= '0;
		end else begin
			samp_a_ff <= SAMPLE_A_I;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			samp_b_ff <= '0;
		end else begin
			samp_b_ff <= SAMPLE_B_I;
		end
	end

	assign corr_on = corr_ff[BIT_CORR_EN];
	assign hold_on = loop_ff[BIT_HOLD] && corr_on;
	assign ped_a_ext = corr_on ? pedestal_ext(ped_a_ff) : '0;
	assign ped_b_ext = corr_on ? pedestal_ext(ped_b_ff) : '0;

	offset_estimator #(
		.DATA_W(DATA_W)
	) u_est_a (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RSTN_I),
		.enable_i(corr_on),
		.hold_i(hold_on),
		.tc_i(loop_ff[TC_MSB:TC_LSB]),
		.pedestal_i(ped_a_ext),
		.sample_i(samp_a_ff),
		.corrected_o(corr_a)
	);

	offset_estimator #(
		.DATA_W(DATA_W)
	) u_est_b (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RSTN_I),
		.enable_i(corr_on),
		.hold_i(hold_on),
		.tc_i(loop_ff[TC_MSB:TC_LSB]),
		.pedestal_i(ped_b_ext),
		.sample_i(samp_b_ff),
		.corrected_o(corr_b)
	);

	// Capture, 15 stages and output register:
	// output loads 16 edges after the capture edge
	latency_line #(
		.WIDTH(PIPE_W),
		.DEPTH(LATENCY_CYCLES - 1)
	) u_delay (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RSTN_I),
		.data_i({corr_a, corr_b}),
		.data_o(pipe_out)
	);

	assign fmt_a = out_format(pipe_out[PIPE_W-1:DATA_W], fmt_ff[FMT_MSB:FMT_LSB]);
	assign fmt_b = out_format(pipe_out[DATA_W-1:0], fmt_ff[FMT_MSB:FMT_LSB]);

	// Output registers, one per channel
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			data_a_ff <= '0;
		end else begin
			data_a_ff <= fmt_a;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			data_b_ff <= '0;
		end else begin
			data_b_ff <= fmt_b;
		end
	end

	assign DATA_A_O = data_a_ff;
	assign DATA_B_O = data_b_ff;
endmodule

// File: tb/adc_cfg_checker.sv
`timescale 1ns/10ps
module adc_cfg_checker
	import adc_cfg_pkg::*;
#(parameter int DATA_W = 14) (
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	input wire logic [DATA_W-1:0] SAMPLE_A_I,
	input wire logic [DATA_W-1:0] SAMPLE_B_I,
	input wire logic [DATA_W-1:0] DATA_A_O,
	input wire logic [DATA_W-1:0] DATA_B_O,
	input wire logic HIGH_FREQ_B_O,
	input wire logic SLOW_RATE_A_O,
	input wire logic SLOW_RATE_B_O,
	input wire logic [5:0] SWING_CODE_O,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O
);
	logic [7:0] sh_ff [12];
	logic wr_ff;
	logic [3:0] idx_ff;
	logic [4:0] age_ff;
	logic [DATA_W-1:0] flip;
	logic raw;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	assign flip = {sh_ff[9][FMT_MSB:FMT_LSB] == FMT_OFFSET_BIN, {(DATA_W-1){1'b0}}};
	assign raw = !sh_ff[8][BIT_CORR_EN] && age_ff > 5'h13;
	// Shadow of the registers, rebuilt from bus writes
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			wr_ff <= 1'b0;
			idx_ff <= 4'h0;
		end else if (HREADY_I) begin
			wr_ff <= HSEL_I && HTRANS_I[1] && HWRITE_I && HADDR_I[31:6] == 26'h0;
			idx_ff <= HADDR_I[5:2];
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sh_ff <= '{default: 8'h00};
			age_ff <= 5'h00;
		end else if (wr_ff && idx_ff < 4'hb) begin
			sh_ff[idx_ff] <= HWDATA_I[7:0];
			age_ff <= 5'h00;
		end else if (age_ff != 5'h1f) begin
			age_ff <= age_ff + 5'h01;
		end
	end
	high_freq_a: assert property (
		age_ff > 5'h02 |-> HIGH_FREQ_B_O == sh_ff[0][BIT_HIGH_FREQ_B]) else $error("hf mode");
	slow_b_a: assert property (
		age_ff > 5'h02 |-> SLOW_RATE_B_O == (sh_ff[4][BIT_SLOW_B] && sh_ff[5][BIT_SLOW_GATE]))
		else $error("slow b");
	slow_a_a: assert property (
		age_ff > 5'h02 |-> SLOW_RATE_A_O == (sh_ff[7][BIT_SLOW_A] && sh_ff[5][BIT_SLOW_GATE]))
		else $error("slow a");
	slow_gate_a: assert property (
		(age_ff > 5'h02 && !sh_ff[5][BIT_SLOW_GATE])[*2] |=> !SLOW_RATE_A_O && !SLOW_RATE_B_O)
		else $error("slow gate");
	swing_gate_a: assert property (
		age_ff > 5'h02 |-> SWING_CODE_O == ((sh_ff[6][1:0] == SWING_GATE_ON) ?
		sh_ff[10][SWING_MSB:SWING_LSB] : SWING_DEFAULT)) else $error("swing");
	latency_a_a: assert property (
		raw |-> DATA_A_O == ($past(SAMPLE_A_I, 17) ^ flip)) else $error("lane a");
	latency_b_a: assert property (
		raw |-> DATA_B_O == ($past(SAMPLE_B_I, 17) ^ flip)) else $error("lane b");
	lanes_same_a: assert property (
		raw && $past(SAMPLE_A_I, 17) == $past(SAMPLE_B_I, 17) |-> DATA_A_O == DATA_B_O)
		else $error("lanes");
	bus_okay_a: assert property (
		HREADYOUT_O && !HRESP_O) else $error("bus response");
endmodule
bind adc_offset_and_mode_config adc_cfg_checker #(.DATA_W(DATA_W)) u_adc_cfg_checker (
	.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
	.SAMPLE_A_I(SAMPLE_A_I), .SAMPLE_B_I(SAMPLE_B_I), .DATA_A_O(DATA_A_O),
	.DATA_B_O(DATA_B_O), .HIGH_FREQ_B_O(HIGH_FREQ_B_O), .SLOW_RATE_A_O(SLOW_RATE_A_O),
	.SLOW_RATE_B_O(SLOW_RATE_B_O), .SWING_CODE_O(SWING_CODE_O),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O));

// File: tb/ahb_host.sv
`timescale 1ns/10ps
module ahb_host
	import adc_cfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output logic hsel_o,
	output logic [31:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [2:0] hsize_o,
	output logic [31:0] hwdata_o
);
	initial begin
		hsel_o = 1'b0;
		haddr_o = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o = HSIZE_WORD;
		hwdata_o = 32'h0;
	end
	// Read data is taken at the edge that ends the data phase
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d,
		output logic [31:0] rd);
		@(posedge clk_i);
		hsel_o <= 1'b1;
		htrans_o <= HTRANS_NONSEQ;
		haddr_o <= a;
		hwrite_o <= wr;
		do @(posedge clk_i); while (hready_i !== 1'b1);
		hsel_o <= 1'b0;
		htrans_o <= 2'h0;
		hwdata_o <= {24'h0, d};
		do @(posedge clk_i); while (hready_i !== 1'b1);
		rd = hrdata_i;
	endtask
	task automatic swing(input logic [1:0] g, input logic [5:0] c);
		logic [31:0] rd;
		xfer(1'b1, OFS_SWING_GATE, {6'h0, g}, rd);
		xfer(1'b1, OFS_SWING_CODE, {c, 2'h0}, rd);
	endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import adc_cfg_pkg::*;
	logic clk, rst_n, hsel, hwrite, hready, hresp, hf, sla, slb, rnd_on;
	logic [31:0] haddr, hwdata, hrdata, lfsr, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [13:0] sa, sb, da, db, base_a, base_b;
	logic [5:0] swing;
	logic [7:0] masks [11];
	logic [31:0] rq[$];
	logic [27:0] dq[$];
	int num_errors, n_compared;
	event rev, dev;
	adc_offset_and_mode_config #(.DATA_W(14)) u_adc_offset_and_mode_config (
		.CORE_CLK_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .SAMPLE_A_I(sa),
		.SAMPLE_B_I(sb), .DATA_A_O(da), .DATA_B_O(db), .HIGH_FREQ_B_O(hf),
		.SLOW_RATE_A_O(sla), .SLOW_RATE_B_O(slb), .SWING_CODE_O(swing));
	ahb_host u_ahb_host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
		.haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
		.hwdata_o(hwdata));
	function automatic logic [31:0] nxt_rand(input logic [31:0] v);
		return {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h0);
	endfunction
	task automatic stop_test();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH hrdata exp %h got %h", e, g);
		end
	endtask
	// Settled estimator may sit one code off
	task automatic cmp_data(input string n, input logic [13:0] e, input logic [13:0] g);
		n_compared++;
		if (g !== e && g !== e + 14'h1 && g !== e - 14'h1) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		u_ahb_host.xfer(1'b1, a, d, rd);
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		rq.push_back(e);
		u_ahb_host.xfer(1'b0, a, 8'h0, rd);
		-> rev;
	endtask
	task automatic dchk(input logic [13:0] ea, input logic [13:0] eb);
		@(negedge clk);
		dq.push_back({ea, eb});
		-> dev;
	endtask
	always @(posedge clk) begin
		lfsr <= nxt_rand(lfsr);
		sa <= rnd_on ? lfsr[13:0] : base_a;
		sb <= rnd_on ? lfsr[31:18] : base_b;
	end
	initial begin
		forever begin
			@(rev);
			cmp_reg(rq.pop_front(), rd);
		end
	end
	initial begin
		logic [27:0] x;
		forever begin
			@(dev);
			x = dq.pop_front();
			cmp_data("data_a", x[27:14], da);
			cmp_data("data_b", x[13:0], db);
		end
	end
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#(8 * 20000);
		num_errors++;
		stop_test();
	end
	initial begin
		logic [7:0] v;
		masks = '{MASK_HIGH_FREQ, MASK_PEDESTAL, MASK_PEDESTAL, MASK_LOOP, MASK_SLOW_B,
			MASK_SLOW_GATE, MASK_SWING_GATE, MASK_SLOW_A, MASK_CORR, MASK_FORMAT, MASK_SWING};
		num_errors = 0;
		n_compared = 0;
		rst_n = 1'b0;
		lfsr = 32'h947d0837;
		rnd_on = 1'b1;
		base_a = 14'h0;
		base_b = 14'h0;
		sa = 14'h0;
		sb = 14'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			if (i != 11) begin
				rchk(32'(i * 4), 32'h0);
			end
		end
		for (int i = 0; i < 11; i++) begin
			v = lfsr[7:0] & masks[i];
			wr(32'(i * 4), v);
			rchk(32'(i * 4), {24'h0, v});
		end
		wr(OFS_CORR_ENABLE, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr(OFS_SLOW_SEL_A, {4'h0, k[0], 3'h0});
			wr(OFS_SLOW_SEL_B, {7'h0, k[1]});
			wr(OFS_SLOW_GATE, {3'h0, k[2], 4'h0});
			u_ahb_host.swing(k[1:0], 6'h3e);
			wr(OFS_HIGH_FREQ_B, {7'h0, k[0]});
			wr(OFS_DATA_FORMAT, {3'h0, k[1:0], 3'h0});
			repeat (40) @(posedge clk);
			rchk(OFS_STATUS, {28'h0, k[1] & k[0], k[0] & k[2], k[1] & k[2], k[0]});
		end
		wr(OFS_DATA_FORMAT, 8'h00);
		base_a <= {{4{lfsr[9]}}, lfsr[9:0]};
		base_b <= {{4{lfsr[25]}}, lfsr[25:16]};
		rnd_on <= 1'b0;
		wr(OFS_PEDESTAL_A, 8'h7c);
		wr(OFS_PEDESTAL_B, 8'h80);
		wr(OFS_LOOP_CTRL, 8'h00);
		wr(OFS_CORR_ENABLE, 8'h20);
		repeat (2000) @(posedge clk);
		dchk(14'h001f, 14'h3fe0);
		wr(OFS_LOOP_CTRL, 8'h80);
		base_a <= base_a + 14'h5;
		repeat (100) @(posedge clk);
		dchk(14'h0024, 14'h3fe0);
		wr(OFS_LOOP_CTRL, 8'h3c);
		repeat (100) @(posedge clk);
		dchk(14'h0024, 14'h3fe0);
		wr(OFS_LOOP_CTRL, 8'h00);
		repeat (2000) @(posedge clk);
		dchk(14'h001f, 14'h3fe0);
		wr(OFS_CORR_ENABLE, 8'h00);
		rnd_on <= 1'b1;
		repeat (40) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk(OFS_PEDESTAL_A, 32'h0);
		repeat (40) @(posedge clk);
		stop_test();
	end
endmodule
